/* nsi_lamp_regs.vh */
/*
 * Register offsets, field positions, reset values and timing constants
 * for the node status lamp controller.
 * Assumes byte addressing on a 32-bit AHB-Lite bus, one word per register.
 */
`ifndef NSI_LAMP_REGS_VH
`define NSI_LAMP_REGS_VH

// Register byte offsets
`define NSI_OFF_CTRL 8'h00
`define NSI_OFF_LINK 8'h04
`define NSI_OFF_IO 8'h08
`define NSI_OFF_STAT 8'h0c

// Health/control register fields
`define NSI_CTRL_CFG_BAD 0
`define NSI_CTRL_REC_FAULT 1
`define NSI_CTRL_UNREC_FAULT 2
`define NSI_CTRL_SELF_TEST 3
`define NSI_CTRL_RST 32'h0000_0000

// Link condition register fields
`define NSI_LINK_COMM_PWR 0
`define NSI_LINK_DUP_DONE 1
`define NSI_LINK_CONN_EST 2
`define NSI_LINK_IO_TIMEOUT 3
`define NSI_LINK_ERROR 4
`define NSI_LINK_RST 32'h0000_0000

// I/O condition register fields
`define NSI_IO_OUT_ACTIVE 0
`define NSI_IO_OUT_IDLE 1
`define NSI_IO_OUT_FAULT 2
`define NSI_IO_OUT_FORCED 3
`define NSI_IO_IN_ACTIVE 4
`define NSI_IO_IN_FAULT 5
`define NSI_IO_IN_UNREC 6
`define NSI_IO_RST 32'h0000_0000

// Status register fields
`define NSI_STAT_LAMPS_LSB 0
`define NSI_STAT_TEST_DONE 8
`define NSI_STAT_RATE_LSB 9
`define NSI_STAT_RATE_OK 11
`define NSI_STAT_ADDR_LSB 16

// Lamp modes
`define NSI_LM_OFF 3'h0
`define NSI_LM_GRN 3'h1
`define NSI_LM_RED 3'h2
`define NSI_LM_FGRN 3'h3
`define NSI_LM_FRED 3'h4
`define NSI_LM_FALT 3'h5

// Data-rate switch codes and rates in kbit/s
`define NSI_DR_125 2'h0
`define NSI_DR_250 2'h1
`define NSI_DR_500 2'h2
`define NSI_KBPS_125 10'h07d
`define NSI_KBPS_250 10'h0fa
`define NSI_KBPS_500 10'h1f4

// Timing in milliseconds and clock rate in Hz
`define NSI_TEST_PHASE_MS 250
`define NSI_FLASH_HALF_MS 500
`define NSI_CLK_HZ 250000000

`endif

/* nsi_lamp_ctrl.v */
/*
 * Node status lamp controller: power-up lamp test, module health, link,
 * combined and I/O lamp colour mapping with flash cadence, data-rate
 * switch decode, AHB-Lite register slave.
 * Assumes one clock, switches on asynchronous pins, condition flags
 * written by software, lamps driven active high per colour.
 */
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "nsi_lamp_regs.vh"

// Summary of operation
// - Module lamp: off, green, flash green, flash red, red, red-green flash.
// - Link lamp off until address check done and link circuitry powered.
// - On-line link lamp flashes green without connections, green with.
// - Link lamp flashes red while any I/O connection is timed out.
// - Link lamp steady red when an error blocks link communication.
// - Power-up: module green, red 0.25 s, then link green, red, off.
// - Combined lamp shows green then red 0.25 s each, then off.
// - Combined lamp off while node is not on-line, unless steady red for a powered-link fault or error.
// - Combined lamp green when normal, on-line, connections established.
// - Combined lamp flashes green without connections or with bad config.
// - Combined lamp flashes red on recoverable fault or I/O timeout.
// - Combined lamp steady red on unrecoverable communication-stopping fault.
// - I/O lamp off when all inputs and outputs are inactive.
// - I/O lamp flashes green when an output is idle, none active or faulted.
// - I/O lamp green when an output or input is active, none faulted.
// - I/O lamp flashes red when any output or input is faulted.
// - I/O lamp red on forced-off output or unrecoverable input fault.
// - Flashing lamps lit 0.5 s and dark 0.5 s, once per second.
// - Data-rate switch 0, 1, 2 decodes to 125, 250, 500 kbit/s.
module nsi_lamp_ctrl #(
    parameter [31:0] CLK_HZ = `NSI_CLK_HZ,
    parameter [31:0] TEST_CYC = CLK_HZ / 1000 * `NSI_TEST_PHASE_MS,
    parameter [31:0] FLASH_CYC = CLK_HZ / 1000 * `NSI_FLASH_HALF_MS
) (
    // Clock, reset, enable
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    // AHB-Lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output reg [31:0] hrdata_o,
    // Switches
    input wire [1:0] data_rate_switches_i,
    input wire [5:0] node_address_switches_i,
    // Decoded switches
    output reg [9:0] data_rate_kbps_o,
    output reg data_rate_valid_o,
    output reg [5:0] node_address_o,
    // Lamps
    output reg module_health_lamp_grn_o,
    output reg module_health_lamp_red_o,
    output reg link_status_lamp_grn_o,
    output reg link_status_lamp_red_o,
    output reg combined_health_link_lamp_grn_o,
    output reg combined_health_link_lamp_red_o,
    output reg io_lamp_grn_o,
    output reg io_lamp_red_o
);

    // Test sequencer states
    localparam [4:0] ST_MG = 5'h01;
    localparam [4:0] ST_MR = 5'h02;
    localparam [4:0] ST_LG = 5'h04;
    localparam [4:0] ST_LR = 5'h08;
    localparam [4:0] ST_RUN = 5'h10;

    // Lamp colours as {red, green}
    function [1:0] nsi_lamp;
        input [2:0] mode;
        input lit;
        begin
            case (mode)
                `NSI_LM_OFF: nsi_lamp = 2'h0;
                `NSI_LM_GRN: nsi_lamp = 2'h1;
                `NSI_LM_RED: nsi_lamp = 2'h2;
                `NSI_LM_FGRN: nsi_lamp = {1'b0, lit};
                `NSI_LM_FRED: nsi_lamp = {lit, 1'b0};
                `NSI_LM_FALT: nsi_lamp = {lit, ~lit};
                default: nsi_lamp = 2'h0;
            endcase
        end
    endfunction

    reg [31:0] ctrl_reg;
    reg [31:0] link_reg;
    reg [31:0] io_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [31:0] test_cnt_reg;
    reg [31:0] flash_cnt_reg;
    reg flash_lit_reg;
    reg [1:0] dr_meta_reg;
    reg [1:0] dr_sync_reg;
    reg [5:0] na_meta_reg;
    reg [5:0] na_sync_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    reg [31:0] rd_next;
    reg [2:0] ms_mode;
    reg [2:0] ls_mode;
    reg [2:0] cm_mode;
    reg [2:0] io_mode;
    reg [1:0] ms_col;
    reg [1:0] ls_col;
    reg [1:0] cm_col;
    reg [1:0] io_col;
    reg [9:0] kbps_next;
    reg rate_ok_next;

    wire addr_phase;
    wire test_end;
    wire online;
    wire [7:0] lamps;

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign addr_phase = hsel_i & htrans_i[1] & hready_i;
    assign test_end = (test_cnt_reg == TEST_CYC - 32'h1);
    assign online = link_reg[`NSI_LINK_COMM_PWR] &
        link_reg[`NSI_LINK_DUP_DONE];
    assign lamps = {io_lamp_red_o, io_lamp_grn_o,
        combined_health_link_lamp_red_o, combined_health_link_lamp_grn_o,
        link_status_lamp_red_o, link_status_lamp_grn_o,
        module_health_lamp_red_o, module_health_lamp_grn_o};

    // Switch synchronisers
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dr_meta_reg <= 2'h0;
            dr_sync_reg <= 2'h0;
            na_meta_reg <= 6'h00;
            na_sync_reg <= 6'h00;
        end else if (ce_i) begin
            dr_meta_reg <= data_rate_switches_i;
            dr_sync_reg <= dr_meta_reg;
            na_meta_reg <= node_address_switches_i;
            na_sync_reg <= na_meta_reg;
        end
    end

    always @* begin
        rate_ok_next = 1'b1;
        case (dr_sync_reg)
            `NSI_DR_125: kbps_next = `NSI_KBPS_125;
            `NSI_DR_250: kbps_next = `NSI_KBPS_250;
            `NSI_DR_500: kbps_next = `NSI_KBPS_500;
            default: begin
                kbps_next = 10'h000;
                rate_ok_next = 1'b0;
            end
        endcase
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_MG: if (test_end) state_next = ST_MR;
            ST_MR: if (test_end) state_next = ST_LG;
            ST_LG: if (test_end) state_next = ST_LR;
            ST_LR: if (test_end) state_next = ST_RUN;
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_MG;
        endcase
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_MG;
            test_cnt_reg <= 32'h0;
            flash_cnt_reg <= 32'h0;
            flash_lit_reg <= 1'b1;
        end else if (ce_i) begin
            state_reg <= state_next;
            if (test_end || state_reg == ST_RUN)
                test_cnt_reg <= 32'h0;
            else
                test_cnt_reg <= test_cnt_reg + 32'h1;
            // 0.5 s lit, 0.5 s dark
            if (flash_cnt_reg == FLASH_CYC - 32'h1) begin
                flash_cnt_reg <= 32'h0;
                flash_lit_reg <= ~flash_lit_reg;
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 32'h1;
            end
        end
    end

    // Normal lamp meanings
    always @* begin
        if (ctrl_reg[`NSI_CTRL_SELF_TEST])
            ms_mode = `NSI_LM_FALT;
        else if (ctrl_reg[`NSI_CTRL_UNREC_FAULT])
            ms_mode = `NSI_LM_RED;
        else if (ctrl_reg[`NSI_CTRL_REC_FAULT])
            ms_mode = `NSI_LM_FRED;
        else if (ctrl_reg[`NSI_CTRL_CFG_BAD])
            ms_mode = `NSI_LM_FGRN;
        else
            ms_mode = `NSI_LM_GRN;
        if (!online)
            ls_mode = `NSI_LM_OFF;
        else if (link_reg[`NSI_LINK_ERROR])
            ls_mode = `NSI_LM_RED;
        else if (link_reg[`NSI_LINK_IO_TIMEOUT])
            ls_mode = `NSI_LM_FRED;
        else if (link_reg[`NSI_LINK_CONN_EST])
            ls_mode = `NSI_LM_GRN;
        else
            ls_mode = `NSI_LM_FGRN;
        if (link_reg[`NSI_LINK_COMM_PWR] &&
            (ctrl_reg[`NSI_CTRL_UNREC_FAULT] || link_reg[`NSI_LINK_ERROR]))
            cm_mode = `NSI_LM_RED;
        else if (!online)
            cm_mode = `NSI_LM_OFF;
        else if (ctrl_reg[`NSI_CTRL_REC_FAULT] ||
                 link_reg[`NSI_LINK_IO_TIMEOUT])
            cm_mode = `NSI_LM_FRED;
        else if (ctrl_reg[`NSI_CTRL_CFG_BAD] ||
                 !link_reg[`NSI_LINK_CONN_EST])
            cm_mode = `NSI_LM_FGRN;
        else
            cm_mode = `NSI_LM_GRN;
        if (io_reg[`NSI_IO_OUT_FORCED] || io_reg[`NSI_IO_IN_UNREC])
            io_mode = `NSI_LM_RED;
        else if (io_reg[`NSI_IO_OUT_FAULT] || io_reg[`NSI_IO_IN_FAULT])
            io_mode = `NSI_LM_FRED;
        else if (io_reg[`NSI_IO_OUT_ACTIVE] || io_reg[`NSI_IO_IN_ACTIVE])
            io_mode = `NSI_LM_GRN;
        else if (io_reg[`NSI_IO_OUT_IDLE])
            io_mode = `NSI_LM_FGRN;
        else
            io_mode = `NSI_LM_OFF;
    end

    // Lamp test overrides
    always @* begin
        ms_col = nsi_lamp(ms_mode, flash_lit_reg);
        ls_col = nsi_lamp(ls_mode, flash_lit_reg);
        cm_col = nsi_lamp(cm_mode, flash_lit_reg);
        io_col = nsi_lamp(io_mode, flash_lit_reg);
        case (state_reg)
            ST_MG: begin
                ms_col = 2'h1;
                ls_col = 2'h0;
                cm_col = 2'h1;
            end
            ST_MR: begin
                ms_col = 2'h2;
                ls_col = 2'h0;
                cm_col = 2'h2;
            end
            ST_LG: begin
                ms_col = 2'h1;
                ls_col = 2'h1;
                cm_col = 2'h0;
            end
            ST_LR: begin
                ms_col = 2'h1;
                ls_col = 2'h2;
                cm_col = 2'h0;
            end
            ST_RUN: ;
            default: begin
                ms_col = 2'h0;
                ls_col = 2'h0;
                cm_col = 2'h0;
            end
        endcase
    end

    // Lamp and decode output flops
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            module_health_lamp_grn_o <= 1'b0;
            module_health_lamp_red_o <= 1'b0;
            link_status_lamp_grn_o <= 1'b0;
            link_status_lamp_red_o <= 1'b0;
            combined_health_link_lamp_grn_o <= 1'b0;
            combined_health_link_lamp_red_o <= 1'b0;
            io_lamp_grn_o <= 1'b0;
            io_lamp_red_o <= 1'b0;
            data_rate_kbps_o <= 10'h000;
            data_rate_valid_o <= 1'b0;
            node_address_o <= 6'h00;
        end else if (ce_i) begin
            module_health_lamp_grn_o <= ms_col[0];
            module_health_lamp_red_o <= ms_col[1];
            link_status_lamp_grn_o <= ls_col[0];
            link_status_lamp_red_o <= ls_col[1];
            combined_health_link_lamp_grn_o <= cm_col[0];
            combined_health_link_lamp_red_o <= cm_col[1];
            io_lamp_grn_o <= io_col[0];
            io_lamp_red_o <= io_col[1];
            data_rate_kbps_o <= kbps_next;
            data_rate_valid_o <= rate_ok_next;
            node_address_o <= na_sync_reg;
        end
    end

    // Read mux
    always @* begin
        rd_next = 32'h0;
        case (haddr_i[7:0])
            `NSI_OFF_CTRL: rd_next = {28'h0, ctrl_reg[3:0]};
            `NSI_OFF_LINK: rd_next = {27'h0, link_reg[4:0]};
            `NSI_OFF_IO: rd_next = {25'h0, io_reg[6:0]};
            `NSI_OFF_STAT: begin
                rd_next[`NSI_STAT_LAMPS_LSB +: 8] = lamps;
                rd_next[`NSI_STAT_TEST_DONE] = (state_reg == ST_RUN);
                rd_next[`NSI_STAT_RATE_LSB +: 2] = dr_sync_reg;
                rd_next[`NSI_STAT_RATE_OK] = rate_ok_next;
                rd_next[`NSI_STAT_ADDR_LSB +: 6] = na_sync_reg;
            end
            default: rd_next = 32'h0;
        endcase
        if (|haddr_i[31:8])
            rd_next = 32'h0;
    end

    // AHB-Lite register access
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= `NSI_CTRL_RST;
            link_reg <= `NSI_LINK_RST;
            io_reg <= `NSI_IO_RST;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_o <= 32'h0;
        end else if (ce_i) begin
            if (hready_i)
                wr_pend_reg <= addr_phase & hwrite_i & ~(|haddr_i[31:8]);
            if (addr_phase) begin
                wr_addr_reg <= haddr_i[7:0];
                if (!hwrite_i)
                    hrdata_o <= rd_next;
            end
            if (wr_pend_reg) begin
                case (wr_addr_reg)
                    `NSI_OFF_CTRL: ctrl_reg <= {28'h0, hwdata_i[3:0]};
                    `NSI_OFF_LINK: link_reg <= {27'h0, hwdata_i[4:0]};
                    `NSI_OFF_IO: io_reg <= {25'h0, hwdata_i[6:0]};
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
        end
    end

endmodule // nsi_lamp_ctrl

/* nsi_lamp_ctrl_unused_note.v */
`timescale 1ns/100ps

/* nsi_lamp_ctrl_props.sv */
/* Checker for the node status lamp controller, bound to its top module.
   Assumes one clock, asynchronous active-high reset, enable held high. */
`timescale 1ns/100ps
`include "nsi_lamp_regs.vh"
module nsi_lamp_ctrl_props #(
    parameter [31:0] TEST_CYC = 32'd20
) (
    // Clock and bus
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [31:0] hrdata_o,
    // Switches
    input wire [1:0] data_rate_switches_i,
    input wire [9:0] data_rate_kbps_o,
    input wire data_rate_valid_o,
    // Lamps
    input wire module_health_lamp_grn_o,
    input wire module_health_lamp_red_o,
    input wire link_status_lamp_grn_o,
    input wire link_status_lamp_red_o,
    input wire combined_health_link_lamp_grn_o,
    input wire combined_health_link_lamp_red_o,
    input wire io_lamp_grn_o,
    input wire io_lamp_red_o
);
    wire [7:0] lamps = {io_lamp_red_o, io_lamp_grn_o,
        combined_health_link_lamp_red_o, combined_health_link_lamp_grn_o,
        link_status_lamp_red_o, link_status_lamp_grn_o,
        module_health_lamp_red_o, module_health_lamp_grn_o};
    wire rd_taken = hsel_i & htrans_i[1] & hready_i & ce_i & ~hwrite_i;
    wire [9:0] kbps_exp =
        (data_rate_switches_i == `NSI_DR_125) ? `NSI_KBPS_125 :
        (data_rate_switches_i == `NSI_DR_250) ? `NSI_KBPS_250 :
        (data_rate_switches_i == `NSI_DR_500) ? `NSI_KBPS_500 : 10'h000;
    reg [31:0] cyc_cnt;
    wire [31:0] ph = cyc_cnt / TEST_CYC;
    wire [31:0] pos = cyc_cnt % TEST_CYC;
    // Away from phase edges, one cycle of slack either side
    wire mid = (pos >= 32'd2) && (pos <= TEST_CYC - 32'd2);

    // Enabled cycles since reset release, saturating
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_cnt <= 32'h0000_0000;
        end else if (ce_i && cyc_cnt != 32'h0000_ffff) begin
            cyc_cnt <= cyc_cnt + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
    AST_RD_UNMAPPED: assert property
        (rd_taken && haddr_i > 32'h0000_000c |=> hrdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_RD_STANDS: assert property (!rd_taken |=> $stable(hrdata_o))
        else $error("read data changed without a read");
    AST_PU_MOD_GRN: assert property
        (mid && ph == 32'd0 |-> lamps[5:0] == 6'h11)
        else $error("power-up green phase wrong");
    AST_PU_MOD_RED: assert property
        (mid && ph == 32'd1 |-> lamps[5:0] == 6'h22)
        else $error("power-up red phase wrong");
    AST_PU_LINK_GRN: assert property
        (mid && ph == 32'd2 |-> lamps[5:0] == 6'h05)
        else $error("power-up link green phase wrong");
    AST_PU_LINK_RED: assert property
        (mid && ph == 32'd3 |-> lamps[5:0] == 6'h09)
        else $error("power-up link red phase wrong");
    AST_ONE_COLOUR: assert property
        ((lamps & (lamps >> 1) & 8'h55) == 8'h00)
        else $error("lamp lit in both colours");
    AST_RATE_DECODE: assert property
        ((cyc_cnt > 32'd8 && $stable(data_rate_switches_i)) [*4]
        |-> data_rate_kbps_o == kbps_exp)
        else $error("rate decode wrong");
    AST_RATE_VALID: assert property
        (data_rate_valid_o == (data_rate_kbps_o != 10'h000))
        else $error("rate valid disagrees with rate");

    cover property (rd_taken && haddr_i > 32'h0000_000c);
    cover property (data_rate_valid_o && data_rate_kbps_o == `NSI_KBPS_500);
    cover property (link_status_lamp_red_o && cyc_cnt > 4 * TEST_CYC);
endmodule // nsi_lamp_ctrl_props

/* nsi_panel_model.sv */
/* Operator panel model: data-rate and address switches with contact
   bounce off the clock grid.
   Assumes the bench commands each setting; pins feed synchronisers. */
`timescale 1ns/100ps
module nsi_panel_model (
    // Commanded settings
    input wire [1:0] rate_set_i,
    input wire [5:0] addr_set_i,
    // Switch pins
    output logic [1:0] data_rate_switches_o,
    output logic [5:0] node_address_switches_o
);
    // Bounce through the inverse before settling
    always @(rate_set_i or addr_set_i) begin
        data_rate_switches_o = ~rate_set_i;
        node_address_switches_o = ~addr_set_i;
        #1.3;
        data_rate_switches_o = rate_set_i;
        node_address_switches_o = addr_set_i;
    end
endmodule // nsi_panel_model

/* node_status_indicator_ctrl_tb.sv */
/* Self-checking bench for the node status lamp controller.
   Assumes short sim counts and a bus slave with no wait states. */
`timescale 1ns/100ps
`include "nsi_lamp_regs.vh"
module node_status_indicator_ctrl_tb;
    localparam int TC = 20;
    localparam int FC = 16;
    localparam int WIN = 2 * FC + 2;
    localparam [2:0] OFF = `NSI_LM_OFF, GRN = `NSI_LM_GRN, RED = `NSI_LM_RED;
    localparam [2:0] FG = `NSI_LM_FGRN, FR = `NSI_LM_FRED, FA = `NSI_LM_FALT;
    typedef struct {
        logic [3:0] h;
        logic [4:0] l;
        logic [6:0] io;
        int idx;
        logic [2:0] m;
    } nsi_row_t;
    nsi_row_t rows [29] = '{
        '{4'h0, 5'h00, 7'h00, 0, GRN}, '{4'h1, 5'h00, 7'h00, 0, FG},
        '{4'h2, 5'h00, 7'h00, 0, FR}, '{4'h4, 5'h00, 7'h00, 0, RED},
        '{4'h8, 5'h00, 7'h00, 0, FA}, '{4'hf, 5'h00, 7'h00, 0, FA},
        '{4'h0, 5'h00, 7'h00, 1, OFF}, '{4'h0, 5'h01, 7'h00, 1, OFF},
        '{4'h0, 5'h02, 7'h00, 1, OFF}, '{4'h0, 5'h03, 7'h00, 1, FG},
        '{4'h0, 5'h07, 7'h00, 1, GRN}, '{4'h0, 5'h0f, 7'h00, 1, FR},
        '{4'h0, 5'h17, 7'h00, 1, RED}, '{4'h0, 5'h02, 7'h00, 2, OFF},
        '{4'h0, 5'h07, 7'h00, 2, GRN}, '{4'h0, 5'h03, 7'h00, 2, FG},
        '{4'h1, 5'h07, 7'h00, 2, FG}, '{4'h2, 5'h07, 7'h00, 2, FR},
        '{4'h0, 5'h0f, 7'h00, 2, FR}, '{4'h4, 5'h07, 7'h00, 2, RED},
        '{4'h0, 5'h07, 7'h00, 3, OFF}, '{4'h0, 5'h07, 7'h02, 3, FG},
        '{4'h0, 5'h07, 7'h01, 3, GRN}, '{4'h0, 5'h07, 7'h10, 3, GRN},
        '{4'h0, 5'h07, 7'h04, 3, FR}, '{4'h0, 5'h07, 7'h20, 3, FR},
        '{4'h0, 5'h07, 7'h06, 3, FR}, '{4'h0, 5'h07, 7'h08, 3, RED},
        '{4'h0, 5'h07, 7'h40, 3, RED}};
    logic [5:0] pu [5] = '{6'h11, 6'h22, 6'h05, 6'h09, 6'h01};
    logic [9:0] kb_exp [4] = '{`NSI_KBPS_125, `NSI_KBPS_250,
        `NSI_KBPS_500, 10'h000};
    logic clk_sys_i, rst_i, hsel_i, hwrite_i;
    logic [1:0] htrans_i, rate_set;
    logic [5:0] addr_set;
    logic [31:0] haddr_i, hwdata_i, rd;
    logic [2:0] m;
    wire hreadyout_o, hresp_o, dr_valid, mg, mr, lg, lr, cg, cr, ig, ir;
    wire [31:0] hrdata_o;
    wire [9:0] dr_kbps;
    wire [5:0] node_addr, na_sw;
    wire [1:0] dr_sw;
    wire [7:0] lamps = {ir, ig, cr, cg, lr, lg, mr, mg};
    int n_fail = 0;
    int n_compared = 0;
    int n;

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    nsi_lamp_ctrl #(.TEST_CYC(TC), .FLASH_CYC(FC)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .data_rate_switches_i(dr_sw), .node_address_switches_i(na_sw),
        .data_rate_kbps_o(dr_kbps), .data_rate_valid_o(dr_valid),
        .node_address_o(node_addr),
        .module_health_lamp_grn_o(mg), .module_health_lamp_red_o(mr),
        .link_status_lamp_grn_o(lg), .link_status_lamp_red_o(lr),
        .combined_health_link_lamp_grn_o(cg),
        .combined_health_link_lamp_red_o(cr),
        .io_lamp_grn_o(ig), .io_lamp_red_o(ir));
    nsi_panel_model panel_u (.rate_set_i(rate_set), .addr_set_i(addr_set),
        .data_rate_switches_o(dr_sw), .node_address_switches_o(na_sw));

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask

    // Classify a lamp over more than one flash period
    task observe(input int idx, output logic [2:0] mo);
        int g;
        int r;
        int b;
        g = 0;
        r = 0;
        b = 0;
        repeat (WIN) begin
            @(posedge clk_sys_i);
            #1;
            g += (lamps[2 * idx] === 1'b1);
            r += (lamps[2 * idx + 1] === 1'b1);
            b += (lamps[2 * idx] === 1'b1 && lamps[2 * idx + 1] === 1'b1);
        end
        if (b != 0) mo = 3'h7;
        else if (g == 0 && r == 0) mo = OFF;
        else if (g == WIN) mo = GRN;
        else if (r == WIN) mo = RED;
        else if (r == 0) mo = FG;
        else if (g == 0) mo = FR;
        else if (g + r == WIN) mo = FA;
        else mo = 3'h7;
    endtask

    task wait_lvl(input logic v);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end while (lamps[0] !== v && n < 100);
    endtask

    task pu_check;
        int k;
        k = 0;
        for (int p = 0; p < 5; p++) begin
            while (k < TC * p + TC / 2) begin
                @(posedge clk_sys_i);
                k++;
            end
            #1;
            check({26'h0, lamps[5:0]}, {26'h0, pu[p]});
        end
    endtask

    task results;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        hsel_i = 1'b0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        haddr_i = 32'h0;
        hwdata_i = 32'h0;
        rate_set <= 2'h0;
        addr_set <= 6'h15;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        pu_check;
        $display("test power-up done");
        for (int i = 0; i < 3; i++) begin
            xfer(32'(4 * i), 1'b0, 32'h0);
            check(rd, 32'h0);
        end
        xfer({24'h0, `NSI_OFF_LINK}, 1'b1, 32'hffff_ffff);
        xfer({24'h0, `NSI_OFF_LINK}, 1'b0, 32'h0);
        check(rd, 32'h0000_001f);
        xfer(32'h10, 1'b1, 32'hffff_ffff);
        xfer(32'h10, 1'b0, 32'h0);
        check(rd, 32'h0);
        xfer({24'h0, `NSI_OFF_STAT}, 1'b1, 32'hffff_ffff);
        xfer({24'h0, `NSI_OFF_STAT}, 1'b0, 32'h0);
        check(rd & 32'hffc0_f100, 32'h0000_0100);
        xfer({24'h0, `NSI_OFF_LINK}, 1'b1, 32'h0);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            rate_set <= c[1:0];
            addr_set <= 6'h2a ^ 6'(c);
            repeat (6) @(posedge clk_sys_i);
            #1;
            check({15'h0, dr_valid, node_addr, dr_kbps},
                {15'h0, 1'(c < 3), 6'h2a ^ 6'(c), kb_exp[c]});
            xfer({24'h0, `NSI_OFF_STAT}, 1'b0, 32'h0);
            check(rd & 32'h003f_0e00, {10'h0, 6'h2a ^ 6'(c), 4'h0,
                1'(c < 3), 2'(c), 9'h0});
        end
        $display("test rate switches done");
        foreach (rows[i]) begin
            xfer({24'h0, `NSI_OFF_CTRL}, 1'b1, {28'h0, rows[i].h});
            xfer({24'h0, `NSI_OFF_LINK}, 1'b1, {27'h0, rows[i].l});
            xfer({24'h0, `NSI_OFF_IO}, 1'b1, {25'h0, rows[i].io});
            repeat (3) @(posedge clk_sys_i);
            observe(rows[i].idx, m);
            case (rows[i].idx)
                0, 1: check(32'(m), 32'(rows[i].m));
                2: check(32'(m), 32'(rows[i].m));
                default: check(32'(m), 32'(rows[i].m));
            endcase
        end
        $display("test lamp table done");
        xfer({24'h0, `NSI_OFF_CTRL}, 1'b1, 32'h1);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        check(32'(n), 32'(FC));
        wait_lvl(1'b1);
        check(32'(n), 32'(FC));
        $display("test flash cadence done");
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        pu_check;
        xfer({24'h0, `NSI_OFF_CTRL}, 1'b0, 32'h0);
        check(rd, 32'h0);
        $display("test second reset done");
        results;
    end

    initial begin
        repeat (6000) @(posedge clk_sys_i);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results;
    end
endmodule // node_status_indicator_ctrl_tb

bind nsi_lamp_ctrl nsi_lamp_ctrl_props #(.TEST_CYC(TEST_CYC)) props_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .data_rate_switches_i(data_rate_switches_i),
    .data_rate_kbps_o(data_rate_kbps_o),
    .data_rate_valid_o(data_rate_valid_o),
    .module_health_lamp_grn_o(module_health_lamp_grn_o),
    .module_health_lamp_red_o(module_health_lamp_red_o),
    .link_status_lamp_grn_o(link_status_lamp_grn_o),
    .link_status_lamp_red_o(link_status_lamp_red_o),
    .combined_health_link_lamp_grn_o(combined_health_link_lamp_grn_o),
    .combined_health_link_lamp_red_o(combined_health_link_lamp_red_o),
    .io_lamp_grn_o(io_lamp_grn_o), .io_lamp_red_o(io_lamp_red_o));
